// ===== bench/sensor_udp_telegram_framer_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Self-checking bench of the framer
module sensor_udp_telegram_framer_bench;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, lerr;
  logic [7:0] paddr, rx_data, tx_data;
  logic [31:0] pwdata, prdata, rd;
  logic rx_valid, rx_last, tx_valid, tx_last, tx_ready;
  logic [5:0] eval_idx;
  logic [15:0] eval_data, status, port_a, port_b, s0;
  logic trigger, button, eth, warn, cfg, error;
  logic menu_exit, act_src;
  int err_count = 0;
  int samples_checked = 0;
  int n, k;

  // User words tagged by their index
  assign eval_data = {10'h2a5, eval_idx};

  sutf_framer #(.MENU_TIMEOUT_CYC(36'd200)) sutf_framer_i (
    .CLK_SYS_I(clk_sys), .RSTN_I(rstn),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data), .RX_LAST_I(rx_last),
    .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data), .TX_LAST_O(tx_last),
    .TX_READY_I(tx_ready), .EVAL_IDX_O(eval_idx), .EVAL_DATA_I(eval_data),
    .TRIGGER_I(trigger), .BUTTON_I(button), .MENU_EXIT_I(menu_exit),
    .ETH_LINK_I(eth), .ACT_SRC_I(act_src), .WARN_I(warn), .CFG_MEM_I(cfg),
    .ERROR_I(error), .STATUS_O(status), .UDP_PORT_A_O(port_a),
    .UDP_PORT_B_O(port_b)
  );

  sutf_ctrl_model sutf_ctrl_model_i (
    .clk_i(clk_sys), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_last_i(tx_last), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_last_o(rx_last)
  );

  // ========================================
  // Helpers
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    samples_checked++;
    if (a !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // Wait for the next whole telegram
  task automatic wait_tg();
    int n0;
    int t;
    n0 = sutf_ctrl_model_i.n_tg;
    t = 0;
    while (sutf_ctrl_model_i.n_tg == n0 && t < 3000) begin
      @(posedge clk_sys);
      t++;
    end
    chk(32'(t < 3000), 32'h1);
  endtask : wait_tg

  // Header fields of the last telegram
  task automatic chk_tg(input logic [15:0] c, input logic [15:0] tr, input logic [15:0] w,
                        input int len);
    logic [7:0] g [0:135];
    g = sutf_ctrl_model_i.got;
    chk(32'(sutf_ctrl_model_i.got_len), 32'(len));
    chk({g[0], g[1], g[2], g[3]}, 32'hffffffff);
    chk({g[4], g[5], g[8], g[9]}, 32'h0);
    chk({g[12], g[13], g[22], g[23]}, 32'h0);
    chk({16'h0, g[7], g[6]}, {16'h0, c});
    chk({16'h0, g[15], g[14]}, {16'h0, tr});
    chk({g[18], g[19], g[20], g[21]}, 32'h0);
    chk({g[27], g[26], g[29], g[28]}, {16'h0010, w});
  endtask : chk_tg

  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Watchdog
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  // ========================================
  // Test sequence
  initial begin
    {rstn, psel, penable, pwrite, trigger, button, error} = '0;
    {eth, warn, cfg} = 3'b111;
    {menu_exit, act_src} = 2'b00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h16022330);
    apb(1'b1, 8'h04, 32'h12345678);
    apb(1'b0, 8'h04, 32'h0);
    chk({port_b, port_a}, 32'h12345678);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], lerr}, 32'h1);
    wait_tg();
    wait_tg();
    s0 = {sutf_ctrl_model_i.got[25], sutf_ctrl_model_i.got[24]};
    wait_tg();
    chk_tg(16'h5354, 16'h0000, 16'h0178, 136);
    chk({sutf_ctrl_model_i.got[25], sutf_ctrl_model_i.got[24]}, s0 + 16'h1);
    chk({sutf_ctrl_model_i.got[17], sutf_ctrl_model_i.got[16]}, 16'h0a11);
    chk({sutf_ctrl_model_i.got[135], sutf_ctrl_model_i.got[134]}, 16'ha974);
    chk(status, 16'h0a11);
    apb(1'b1, 8'h00, 32'h4);
    wait_tg();
    wait_tg();
    chk(status, 16'h0b11);
    apb(1'b1, 8'h00, 32'h1);
    wait_tg();
    repeat (200) @(posedge clk_sys);
    n = sutf_ctrl_model_i.n_tg;
    chk(status, 16'h0a41);
    sutf_ctrl_model_i.slow = 1'b1;
    sutf_ctrl_model_i.send_cmd(16'h434e);
    wait_tg();
    chk_tg(16'h434e, 16'h434e, 16'h0000, 30);
    sutf_ctrl_model_i.slow = 1'b0;
    button <= 1'b1;
    @(posedge clk_sys);
    button <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(status[7:4], 4'b0010);
    sutf_ctrl_model_i.send_cmd(16'h4e43);
    repeat (60) @(posedge clk_sys);
    chk(sutf_ctrl_model_i.n_tg, n + 1);
    chk(status[5], 1'b1);
    k = 0;
    while (status[5] !== 1'b0 && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    chk(status[5], 1'b0);
    button <= 1'b1;
    {eth, warn, cfg, act_src} <= 4'b0001;
    @(posedge clk_sys);
    button <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(status, 16'h0120);
    menu_exit <= 1'b1;
    @(posedge clk_sys);
    menu_exit <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(status[5], 1'b0);
    {eth, warn, cfg, act_src} <= 4'b1110;
    @(posedge clk_sys);
    apb(1'b1, 8'h00, 32'h2);
    repeat (400) @(posedge clk_sys);
    n = sutf_ctrl_model_i.n_tg;
    repeat (300) @(posedge clk_sys);
    chk(sutf_ctrl_model_i.n_tg, n);
    chk(status, 16'h0e11);
    trigger <= 1'b1;
    @(posedge clk_sys);
    trigger <= 1'b0;
    wait_tg();
    chk_tg(16'h5354, 16'h0000, 16'h0178, 136);
    repeat (300) @(posedge clk_sys);
    chk(sutf_ctrl_model_i.n_tg, n + 1);
    error <= 1'b1;
    @(posedge clk_sys);
    error <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(status[13], 1'b1);
    repeat (300) @(posedge clk_sys);
    chk(status[7:4], 4'b1000);
    apb(1'b1, 8'h08, 32'h2000);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[13], 1'b0);
    tally_and_finish();
  end
endmodule : sensor_udp_telegram_framer_bench
`default_nettype wire

// ===== bench/sutf_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Controller at the far side of the link
module sutf_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Telegrams from the sensor
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  // Telegrams to the sensor
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o
);
  logic [7:0] buf_q [0:135];
  logic [7:0] got [0:135];
  int pos = 0;
  int got_len = 0;
  int n_tg = 0;
  logic slow = 1'b0;
  logic ph = 1'b0;

  // Idle link at time zero
  initial begin
    tx_ready_o = 1'b1;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h5a;
    rx_last_o = 1'b0;
  end

  // Byte sink, stalls every other cycle when slow
  always @(posedge clk_i) begin
    ph <= ~ph;
    tx_ready_o <= ~slow | ph;
    if (tx_valid_i && tx_ready_o && pos < 136) begin
      buf_q[pos] = tx_data_i;
      pos = pos + 1;
      if (tx_last_i) begin
        got = buf_q;
        got_len = pos;
        pos = 0;
        n_tg = n_tg + 1;
      end
    end
  end

  // One command telegram, header only
  task automatic send_cmd(input logic [15:0] cmd);
    logic [7:0] b;
    for (int i = 0; i < 30; i++) begin
      b = (i < 4) ? 8'hff : (i == 26) ? 8'h10 : 8'h00;
      if (i == 6) b = cmd[7:0];
      if (i == 7) b = cmd[15:8];
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= b;
      rx_last_o <= (i == 29);
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask : send_cmd
endmodule : sutf_ctrl_model
`default_nettype wire

// ===== hdl/sutf_framer.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "sutf_regs.svh"

module sutf_framer #(
  parameter logic [35:0] MENU_TIMEOUT_CYC = 36'(64'(`SUTF_MENU_TIMEOUT_MIN) * 64'd60
    * 64'd1000000000 / 64'(`SUTF_CLK_PERIOD_NS))
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Received telegram bytes
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_LAST_I,
  // Transmitted telegram bytes
  output logic TX_VALID_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_LAST_O,
  input wire logic TX_READY_I,
  // Evaluation user data fetch
  output logic [5:0] EVAL_IDX_O,
  input wire logic [15:0] EVAL_DATA_I,
  // Sensor events and levels
  input wire logic TRIGGER_I,
  input wire logic BUTTON_I,
  input wire logic MENU_EXIT_I,
  input wire logic ETH_LINK_I,
  input wire logic ACT_SRC_I,
  input wire logic WARN_I,
  input wire logic CFG_MEM_I,
  input wire logic ERROR_I,
  // Status and ports
  output logic [15:0] STATUS_O,
  output logic [15:0] UDP_PORT_A_O,
  output logic [15:0] UDP_PORT_B_O
);

  sutf_pkg::sutf_state_s q, d;
  logic [15:0] status;
  logic [15:0] word;
  logic [7:0] byte_sel;
  logic [7:0] didx;
  logic apb_setup;
  logic apb_wr;
  logic start_ack;
  logic start_eval;
  sutf_pkg::sutf_mode_e base_mode;

  // ==========================================================
  // Status word
  always_comb begin
    status = 16'h0000;
    status[`SUTF_ST_ETH] = ETH_LINK_I;
    status[`SUTF_ST_DET] = (q.mode == sutf_pkg::SUTF_DET);
    status[`SUTF_ST_MENU] = (q.mode == sutf_pkg::SUTF_MENU);
    status[`SUTF_ST_CMD] = (q.mode == sutf_pkg::SUTF_CMD);
    status[`SUTF_ST_ERRM] = (q.mode == sutf_pkg::SUTF_ERR);
    status[`SUTF_ST_ACT] = q.ctrl[`SUTF_CTRL_ACTDIS] | ACT_SRC_I;
    status[`SUTF_ST_WARN] = WARN_I;
    status[`SUTF_ST_TRIG] = q.ctrl[`SUTF_CTRL_TRIG];
    status[`SUTF_ST_CFGM] = CFG_MEM_I;
    status[`SUTF_ST_ERR] = q.err;
  end

  // ==========================================================
  // Byte of the telegram at the load index
  always_comb begin
    didx = q.idx - `SUTF_HDR_BYTES;
    EVAL_IDX_O = (q.idx >= `SUTF_HDR_BYTES) ? didx[6:1] : 6'h00;
    unique case (q.idx[7:1])
      7'd0, 7'd1: word = `SUTF_START_WORD;
      7'd3: word = q.t_cmd;
      7'd5: word = q.pkt;
      7'd7: word = q.t_trans;
      7'd8: word = q.t_stat;
      7'd9, 7'd10: word = `SUTF_ENC_WORD;
      7'd12: word = q.scan;
      7'd13: word = `SUTF_TYPE_WORD;
      7'd14: word = (q.kind == sutf_pkg::SUTF_ACK) ? `SUTF_WCNT_ACK : `SUTF_WCNT_EVAL;
      7'd2, 7'd4, 7'd6, 7'd11: word = `SUTF_FILL_WORD;
      default: word = EVAL_DATA_I;
    endcase
    byte_sel = q.idx[0] ? word[15:8] : word[7:0];
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    apb_setup = PSEL_I & ~PENABLE_I;
    apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
    base_mode = q.ctrl[`SUTF_CTRL_CMD] ? sutf_pkg::SUTF_CMD : sutf_pkg::SUTF_DET;
    start_ack = ~q.busy & ~q.tx_valid & q.ack_pend & (q.mode == sutf_pkg::SUTF_CMD);
    start_eval = ~q.busy & ~q.tx_valid & (q.mode == sutf_pkg::SUTF_DET)
      & (~q.ctrl[`SUTF_CTRL_TRIG] | q.trig_pend);

    // APB read data sampled in the setup cycle
    if (apb_setup) begin
      d.pslverr = 1'b0;
      unique case (PADDR_I)
        `SUTF_OFS_CTRL: d.prdata = {29'h0, q.ctrl};
        `SUTF_OFS_PORTS: d.prdata = {q.port_b, q.port_a};
        `SUTF_OFS_STATUS: d.prdata = {16'h0, status};
        `SUTF_OFS_SCAN: d.prdata = {q.ack_cmd, q.scan};
        default: begin
          d.prdata = 32'h0;
          d.pslverr = 1'b1;
        end
      endcase
    end

    // APB writes take effect in the access cycle
    if (apb_wr && PADDR_I == `SUTF_OFS_CTRL) begin
      d.ctrl = PWDATA_I[2:0];
    end
    if (apb_wr && PADDR_I == `SUTF_OFS_PORTS) begin
      d.port_a = PWDATA_I[15:0];
      d.port_b = PWDATA_I[31:16];
    end

    // Error flag, write one clears, a new error wins
    if (apb_wr && PADDR_I == `SUTF_OFS_STATUS && PWDATA_I[`SUTF_ST_ERR]) begin
      d.err = 1'b0;
    end
    if (ERROR_I) begin
      d.err = 1'b1;
    end

    // Operating mode
    if (BUTTON_I) begin
      d.mode = sutf_pkg::SUTF_MENU;
      d.menu_cnt = 36'h0;
    end else if (q.mode == sutf_pkg::SUTF_MENU) begin
      if (MENU_EXIT_I || q.menu_cnt == MENU_TIMEOUT_CYC - 36'h1) begin
        d.mode = q.err ? sutf_pkg::SUTF_ERR : base_mode;
        d.menu_cnt = 36'h0;
      end else begin
        d.menu_cnt = q.menu_cnt + 36'h1;
      end
    end else if (!q.busy) begin
      d.mode = q.err ? sutf_pkg::SUTF_ERR : base_mode;
    end

    // Trigger latch
    if (start_eval) begin
      d.trig_pend = 1'b0;
    end
    if (TRIGGER_I && q.ctrl[`SUTF_CTRL_TRIG] && q.mode == sutf_pkg::SUTF_DET) begin
      d.trig_pend = 1'b1;
    end

    // Command receiver
    if (start_ack) begin
      d.ack_pend = 1'b0;
    end
    if (RX_VALID_I) begin
      if (q.rx_cnt < `SUTF_RX_START_END && RX_DATA_I != 8'hff) begin
        d.rx_ok = 1'b0;
      end
      if (q.rx_cnt == `SUTF_RX_CMD_LO) begin
        d.rx_lo = RX_DATA_I;
      end
      if (q.rx_cnt == `SUTF_RX_CMD_HI) begin
        d.rx_cmd = {RX_DATA_I, q.rx_lo};
      end
      d.rx_cnt = (q.rx_cnt == 8'hff) ? q.rx_cnt : q.rx_cnt + 8'h01;
      if (RX_LAST_I) begin
        d.rx_cnt = 8'h00;
        d.rx_ok = 1'b1;
        if (q.rx_ok && q.rx_cnt >= `SUTF_RX_MIN_LAST && q.mode == sutf_pkg::SUTF_CMD) begin
          d.ack_pend = 1'b1;
          d.ack_cmd = q.rx_cmd;
        end
      end
    end

    // Telegram start
    if (start_ack || start_eval) begin
      d.busy = 1'b1;
      d.idx = 8'h00;
      d.kind = start_ack ? sutf_pkg::SUTF_ACK : sutf_pkg::SUTF_EVAL;
      d.len = start_ack ? `SUTF_HDR_BYTES : `SUTF_EVAL_BYTES;
      d.t_cmd = start_ack ? q.ack_cmd : `SUTF_EVAL_CMD;
      d.t_trans = start_ack ? q.ack_cmd : `SUTF_DET_TRANS;
      d.t_stat = status;
      d.pkt = q.pkt + 16'h0001;
    end

    // Byte loader
    if (!q.tx_valid || TX_READY_I) begin
      d.tx_valid = 1'b0;
      d.tx_last = 1'b0;
      if (q.busy && q.idx < q.len) begin
        d.tx_valid = 1'b1;
        d.tx_data = byte_sel;
        d.tx_last = (q.idx == q.len - 8'h01);
        d.out_idx = q.idx;
        d.idx = q.idx + 8'h01;
      end else if (q.busy) begin
        d.busy = 1'b0;
        if (q.kind == sutf_pkg::SUTF_EVAL) begin
          d.scan = q.scan + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q <= '0;
      q.port_a <= `SUTF_PORT_A_RST;
      q.port_b <= `SUTF_PORT_B_RST;
      q.rx_ok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign PRDATA_O = q.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = q.pslverr & PSEL_I & PENABLE_I;
  assign TX_VALID_O = q.tx_valid;
  assign TX_DATA_O = q.tx_data;
  assign TX_LAST_O = q.tx_last;
  assign STATUS_O = status;
  assign UDP_PORT_A_O = q.port_a;
  assign UDP_PORT_B_O = q.port_b;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  AST_START_SEQ: assert property (TX_VALID_O && q.out_idx < 8'd4 |-> TX_DATA_O == 8'hff)
    else $error("start sequence byte not 0xff");
  AST_TYPE_FIELD: assert property (TX_VALID_O && q.out_idx == 8'd26 |-> TX_DATA_O == 8'h10)
    else $error("type field low byte wrong");
  AST_EVAL_CMD: assert property (TX_VALID_O && q.kind == sutf_pkg::SUTF_EVAL && q.out_idx == 8'd6
    |-> TX_DATA_O == 8'h54)
    else $error("evaluation command low byte wrong");
  AST_LSB_FIRST: assert property (TX_VALID_O && TX_READY_I && q.kind == sutf_pkg::SUTF_EVAL
    && q.out_idx == 8'd6 |=> TX_VALID_O && TX_DATA_O == 8'h53)
    else $error("command high byte not following low byte");
  AST_DET_TRANS: assert property (TX_VALID_O && q.kind == sutf_pkg::SUTF_EVAL
    && (q.out_idx == 8'd14 || q.out_idx == 8'd15) |-> TX_DATA_O == 8'h00)
    else $error("detection transaction number not zero");
  AST_ACK_TRANS: assert property (TX_VALID_O && q.kind == sutf_pkg::SUTF_ACK && q.out_idx == 8'd14
    |-> TX_DATA_O == q.t_cmd[7:0])
    else $error("ack transaction number does not echo command");
  AST_ENCODER: assert property (TX_VALID_O && q.out_idx >= 8'd18 && q.out_idx <= 8'd21
    |-> TX_DATA_O == 8'h00)
    else $error("encoder byte not zero");
  AST_MODE_ONEHOT: assert property ($onehot(status[7:4]))
    else $error("mode bits not one-hot");
  AST_ACT_FORCED: assert property (q.ctrl[`SUTF_CTRL_ACTDIS] |-> status[`SUTF_ST_ACT])
    else $error("activation bit not forced");
  AST_MENU_SILENT: assert property (q.mode == sutf_pkg::SUTF_MENU && !q.busy |=> !q.busy)
    else $error("telegram started in menu mode");
  AST_BUTTON_MENU: assert property (BUTTON_I |=> q.mode == sutf_pkg::SUTF_MENU [*2])
    else $error("button did not hold menu mode");
  AST_SCAN_STEP: assert property (q.busy && !d.busy && q.kind == sutf_pkg::SUTF_EVAL
    |=> q.scan == $past(q.scan) + 16'h0001)
    else $error("scan number did not advance");
  AST_ACK_WCNT: assert property (TX_VALID_O && q.kind == sutf_pkg::SUTF_ACK
    |-> q.len == `SUTF_HDR_BYTES && TX_LAST_O == (q.out_idx == 8'd29))
    else $error("ack length wrong");

  COV_EVAL: cover property (TX_VALID_O && TX_LAST_O && q.kind == sutf_pkg::SUTF_EVAL);
  COV_ACK: cover property (TX_VALID_O && TX_LAST_O && q.kind == sutf_pkg::SUTF_ACK);
  COV_MENU_EXIT: cover property (q.mode == sutf_pkg::SUTF_MENU ##1 q.mode != sutf_pkg::SUTF_MENU);
  COV_ERR: cover property (q.mode == sutf_pkg::SUTF_ERR);

endmodule : sutf_framer
`default_nettype wire

// ===== inc/sutf_pkg.sv
`default_nettype none
package sutf_pkg;

  // Operating state
  typedef enum logic [1:0] {
    SUTF_DET = 2'b00,
    SUTF_MENU = 2'b01,
    SUTF_CMD = 2'b10,
    SUTF_ERR = 2'b11
  } sutf_mode_e;

  // Telegram kind in flight
  typedef enum logic {
    SUTF_EVAL = 1'b0,
    SUTF_ACK = 1'b1
  } sutf_kind_e;

  // Whole state of the framer
  typedef struct packed {
    logic [2:0] ctrl;
    logic [15:0] port_a;
    logic [15:0] port_b;
    logic [31:0] prdata;
    logic pslverr;
    sutf_mode_e mode;
    logic [35:0] menu_cnt;
    logic err;
    logic trig_pend;
    logic ack_pend;
    logic [15:0] ack_cmd;
    logic [7:0] rx_cnt;
    logic rx_ok;
    logic [7:0] rx_lo;
    logic [15:0] rx_cmd;
    logic busy;
    sutf_kind_e kind;
    logic [7:0] idx;
    logic [7:0] len;
    logic [15:0] t_cmd;
    logic [15:0] t_trans;
    logic [15:0] t_stat;
    logic [15:0] pkt;
    logic [15:0] scan;
    logic tx_valid;
    logic tx_last;
    logic [7:0] tx_data;
    logic [7:0] out_idx;
  } sutf_state_s;

endpackage : sutf_pkg
`default_nettype wire

// ===== inc/sutf_regs.svh
`ifndef SUTF_REGS_SVH
`define SUTF_REGS_SVH

// ==========================================================
// Register offsets
`define SUTF_OFS_CTRL 8'h00
`define SUTF_OFS_PORTS 8'h04
`define SUTF_OFS_STATUS 8'h08
`define SUTF_OFS_SCAN 8'h0c

// ==========================================================
// Control fields and reset values
`define SUTF_CTRL_CMD 0
`define SUTF_CTRL_TRIG 1
`define SUTF_CTRL_ACTDIS 2
`define SUTF_PORT_A_RST 16'h2330
`define SUTF_PORT_B_RST 16'h1602

// ==========================================================
// Status word fields
`define SUTF_ST_ETH 0
`define SUTF_ST_DET 4
`define SUTF_ST_MENU 5
`define SUTF_ST_CMD 6
`define SUTF_ST_ERRM 7
`define SUTF_ST_ACT 8
`define SUTF_ST_WARN 9
`define SUTF_ST_TRIG 10
`define SUTF_ST_CFGM 11
`define SUTF_ST_ERR 13

// ==========================================================
// Telegram constants
`define SUTF_START_WORD 16'hffff
`define SUTF_FILL_WORD 16'h0000
`define SUTF_EVAL_CMD 16'h5354
`define SUTF_DET_TRANS 16'h0000
`define SUTF_ENC_WORD 16'h0000
`define SUTF_TYPE_WORD 16'h0010
`define SUTF_WCNT_ACK 16'h0000
`define SUTF_WCNT_EVAL 16'h0178
`define SUTF_HDR_BYTES 8'd30
`define SUTF_HDR_WORDS 7'd15
`define SUTF_EVAL_WORDS 8'd53
`define SUTF_EVAL_BYTES 8'd136
`define SUTF_RX_CMD_LO 8'd6
`define SUTF_RX_CMD_HI 8'd7
`define SUTF_RX_START_END 8'd4
`define SUTF_RX_MIN_LAST 8'd29

// ==========================================================
// Timing
`define SUTF_MENU_TIMEOUT_MIN 3
`define SUTF_CLK_PERIOD_NS 5

`endif
